// [core/minute_timer.sv]
// base tick prescaler and periodic one-minute timer with restart
`timescale 1ns/1ns
module minute_timer #(
  parameter int PRESCALE = rss_pkg::TICK_CYCLES,
  parameter int TICKS = rss_pkg::MINUTE_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic baseTick,
  output logic minuteTick
);
  localparam int PW = $clog2(PRESCALE + 1);
  localparam int TW = $clog2(TICKS + 1);

  typedef struct packed {
    logic [PW-1:0] preCnt;
    logic [TW-1:0] tickCnt;
    logic baseTick;
    logic minuteTick;
  } timer_s;

  timer_s r;
  timer_s n;

  always_comb begin
    n = r;
    n.baseTick = 1'b0;
    n.minuteTick = 1'b0;
    if (restart) begin
      n.preCnt = '0;
      n.tickCnt = '0;
    end else if (r.preCnt == PW'(PRESCALE - 1)) begin
      n.preCnt = '0;
      n.baseTick = 1'b1;
      if (r.tickCnt == TW'(TICKS - 1)) begin
        n.tickCnt = '0;
        n.minuteTick = 1'b1;
      end else begin
        n.tickCnt = r.tickCnt + TW'(1);
      end
    end else begin
      n.preCnt = r.preCnt + PW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign baseTick = r.baseTick;
  assign minuteTick = r.minuteTick;
endmodule

// [core/remote_speed_setpoint.sv]
// remote speed setpoint (digital motor potentiometer) with axi4-lite registers
// Summary of operation
// (R1) Output adds remote offset to a base command picked by operating mode.
// (R2) Select 1 keeps offset in non-volatile memory and resumes it on power-up.
// (R3) With storage on, write the setpoint when the start inputs drop.
// (R4) With storage on, check every minute once speed inputs stay unchanged.
// (R5) Minute check writes only if setpoint differs from previous check.
// (R6) Clear input never gates whether or when a write happens.
// (R7) Offset stays between zero and the selected maximum limit.
// (R8) Set frequency is capped at base plus maximum frequency limit.
// (R9) Without second-ramp select use second ramp unless normal ramp is longer.
// (R10) With second-ramp select always use the second ramp times.
// (R11) Speed inputs change the preset even with no start input active.
// (R12) Controller picks select 2 or 3 when toggling inputs often.
// (R13) Jog or PID operation disables the remote function entirely; a select 1 restore still loads the offset during them.
// (R14) Remote function also works in network operating mode.
// (R15) Power return within a minute after clear resumes stored frequency.
// (R16) Power return after a minute past clear resumes cleared frequency.
// (R17) With select 1 the motor restarts after power loss if started.
// (R18) Select 1 to 3 remaps speed inputs; select 0 keeps multi-speed.
// (R19) Select 3 clears the offset when both start inputs turn off.
// (R20) One-minute interval from prescaled clock, restarted on speed input change.
// (R21) Each write is one request pulse; no new one until acknowledged.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module remote_speed_setpoint #(
  parameter int FW = 16,
  parameter int PRESCALE = rss_pkg::TICK_CYCLES,
  parameter int MINUTE_TICKS = rss_pkg::MINUTE_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [rss_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [rss_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic speedUpInput,
  input wire logic speedDownInput,
  input wire logic setpointClearInput,
  input wire logic forwardStartInput,
  input wire logic reverseStartInput,
  input wire logic secondRampSelectInput,
  input wire logic jogActive,
  input wire logic pidActive,
  input wire logic [FW-1:0] panelCmd,
  input wire logic [FW-1:0] externalCmd,
  input wire logic [FW-1:0] terminal4Cmd,
  input wire logic [FW-1:0] networkCmd,
  input wire logic nvmWriteAck,
  input wire logic nvmRestoreValid,
  input wire logic [FW-1:0] nvmRestoreData,
  output logic [FW-1:0] setFreq,
  output logic runRequest,
  output logic [2:0] multiSpeedSel,
  output logic nvmWriteReq,
  output logic [FW-1:0] nvmWriteData
);
  typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic [rss_pkg::ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] remoteSel;
    logic [2:0] opMode;
    logic t4Select;
    logic highSpeedSel;
    logic [15:0] maxLimit;
    logic [15:0] hsLimit;
    logic [15:0] normAccel;
    logic [15:0] normDecel;
    logic [15:0] secAccel;
    logic [15:0] secDecel;
    logic [FW-1:0] offset;
    logic [FW-1:0] lastCheck;
    logic [15:0] stepCnt;
    logic startPrev;
    logic upPrev;
    logic downPrev;
    logic pending;
    logic nvmBusy;
    logic nvmReq;
    logic [FW-1:0] nvmData;
    logic [FW-1:0] setFreq;
    logic runReq;
    logic [2:0] multiSpeed;
  } state_s;

  state_s r;
  state_s n;
  logic baseTick;
  logic minuteTick;
  logic remoteOn;
  logic storeOn;
  logic startNow;
  logic startFall;
  logic speedChange;
  logic wantWrite;
  logic [FW-1:0] baseCmd;
  logic [FW-1:0] curLimit;
  logic [15:0] accelEff;
  logic [15:0] decelEff;
  logic [15:0] stepLim;
  logic [FW:0] sum;
  logic [FW:0] cap;
  logic [31:0] img;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i+:8] = d[8*i+:8];
      end
    end
    return m;
  endfunction

  minute_timer #(
    .PRESCALE(PRESCALE),
    .TICKS(MINUTE_TICKS)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(speedChange),
    .baseTick(baseTick),
    .minuteTick(minuteTick)
  );

  always_comb begin
    n = r;
    n.nvmReq = 1'b0;
    img = '0;
    stepLim = '0;
    wantWrite = 1'b0;
    remoteOn = (r.remoteSel != rss_pkg::SEL_MULTI) && !jogActive && !pidActive; // [R13]
    storeOn = remoteOn && (r.remoteSel == rss_pkg::SEL_STORE);
    startNow = forwardStartInput | reverseStartInput;
    startFall = r.startPrev && !startNow;
    speedChange = (speedUpInput != r.upPrev) || (speedDownInput != r.downPrev); // [R20]
    n.startPrev = startNow;
    n.upPrev = speedUpInput;
    n.downPrev = speedDownInput;
    case (r.opMode) // [R1] [R14]
      rss_pkg::MODE_PANEL: baseCmd = panelCmd;
      rss_pkg::MODE_COMB: baseCmd = r.t4Select ? terminal4Cmd : panelCmd;
      rss_pkg::MODE_NET: baseCmd = networkCmd;
      default: baseCmd = externalCmd;
    endcase
    curLimit = r.highSpeedSel ? FW'(r.hsLimit) : FW'(r.maxLimit);
    accelEff = (!secondRampSelectInput && r.normAccel > r.secAccel) ? r.normAccel
                                                                    : r.secAccel; // [R9] [R10]
    decelEff = (!secondRampSelectInput && r.normDecel > r.secDecel) ? r.normDecel
                                                                    : r.secDecel; // [R9] [R10]
    // ramp the offset regardless of the start inputs
    if (remoteOn && (speedUpInput ^ speedDownInput)) begin // [R11] [R18]
      stepLim = speedUpInput ? accelEff : decelEff;
      if (baseTick) begin
        if (r.stepCnt >= stepLim) begin
          n.stepCnt = '0;
          if (speedUpInput && r.offset < curLimit) begin
            n.offset = r.offset + FW'(1); // [R7]
          end else if (speedDownInput && r.offset != '0) begin
            n.offset = r.offset - FW'(1); // [R7]
          end
        end else begin
          n.stepCnt = r.stepCnt + 16'h0001;
        end
      end
    end else begin
      n.stepCnt = '0;
    end
    if (remoteOn && setpointClearInput) begin
      n.offset = '0; // [R18]
    end
    if (remoteOn && r.remoteSel == rss_pkg::SEL_CLEAR && startFall) begin
      n.offset = '0; // [R19]
    end
    if (r.remoteSel == rss_pkg::SEL_STORE && nvmRestoreValid) begin
      n.offset = nvmRestoreData; // [R2] [R15] [R16]
      n.lastCheck = nvmRestoreData;
    end
    if (n.offset > curLimit) begin
      n.offset = curLimit; // [R7]
    end
    // storage: clear input takes no part in the decision
    if (storeOn && startFall) begin
      wantWrite = 1'b1; // [R3] [R6]
    end
    if (storeOn && minuteTick) begin // [R4]
      n.lastCheck = r.offset;
      if (r.offset != r.lastCheck) begin
        wantWrite = 1'b1; // [R5]
      end
    end
    n.pending = r.pending | wantWrite;
    if (r.nvmBusy && nvmWriteAck) begin
      n.nvmBusy = 1'b0;
    end
    if (!r.nvmBusy && n.pending) begin // [R21]
      n.nvmReq = 1'b1;
      n.nvmBusy = 1'b1;
      n.nvmData = r.offset;
      n.pending = 1'b0;
    end
    // outputs
    sum = {1'b0, baseCmd} + {1'b0, r.offset};
    cap = {1'b0, baseCmd} + {1'b0, FW'(r.maxLimit)};
    if (sum > cap) begin
      sum = cap; // [R8]
    end
    if (!remoteOn) begin
      n.setFreq = baseCmd; // [R13]
    end else if (sum[FW]) begin
      n.setFreq = '1;
    end else begin
      n.setFreq = sum[FW-1:0]; // [R1]
    end
    n.runReq = startNow; // [R17]
    n.multiSpeed = (r.remoteSel == rss_pkg::SEL_MULTI)
                 ? {speedUpInput, speedDownInput, setpointClearInput} : 3'h0; // [R18]
    // axi4-lite write channel
    if (awvalid && r.awready) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && r.wready) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (r.awHeld && r.wHeld && !r.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = rss_pkg::RESP_OKAY;
      case ({r.awAddr[rss_pkg::ADDR_W-1:2], 2'b00})
        rss_pkg::CTRL_OFS: begin
          img[rss_pkg::SEL_LSB+:2] = r.remoteSel;
          img[rss_pkg::MODE_LSB+:3] = r.opMode;
          img[rss_pkg::T4_BIT] = r.t4Select;
          img[rss_pkg::HSL_BIT] = r.highSpeedSel;
          img = merge(img, r.wData, r.wStrb);
          n.remoteSel = img[rss_pkg::SEL_LSB+:2];
          n.opMode = img[rss_pkg::MODE_LSB+:3];
          n.t4Select = img[rss_pkg::T4_BIT];
          n.highSpeedSel = img[rss_pkg::HSL_BIT];
        end
        rss_pkg::LIMIT_OFS: begin
          img = merge({r.hsLimit, r.maxLimit}, r.wData, r.wStrb);
          {n.hsLimit, n.maxLimit} = img;
        end
        rss_pkg::NORM_RAMP_OFS: begin
          img = merge({r.normDecel, r.normAccel}, r.wData, r.wStrb);
          {n.normDecel, n.normAccel} = img;
        end
        rss_pkg::SEC_RAMP_OFS: begin
          img = merge({r.secDecel, r.secAccel}, r.wData, r.wStrb);
          {n.secDecel, n.secAccel} = img;
        end
        rss_pkg::STATUS_OFS, rss_pkg::SETFREQ_OFS: n.bresp = rss_pkg::RESP_OKAY;
        default: n.bresp = rss_pkg::RESP_SLVERR;
      endcase
    end
    n.awready = !n.awHeld && !n.bvalid;
    n.wready = !n.wHeld && !n.bvalid;
    // axi4-lite read channel
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rdata = '0;
      n.rresp = rss_pkg::RESP_OKAY;
      case ({araddr[rss_pkg::ADDR_W-1:2], 2'b00})
        rss_pkg::CTRL_OFS: begin
          n.rdata[rss_pkg::SEL_LSB+:2] = r.remoteSel;
          n.rdata[rss_pkg::MODE_LSB+:3] = r.opMode;
          n.rdata[rss_pkg::T4_BIT] = r.t4Select;
          n.rdata[rss_pkg::HSL_BIT] = r.highSpeedSel;
        end
        rss_pkg::LIMIT_OFS: n.rdata = {r.hsLimit, r.maxLimit};
        rss_pkg::NORM_RAMP_OFS: n.rdata = {r.normDecel, r.normAccel};
        rss_pkg::SEC_RAMP_OFS: n.rdata = {r.secDecel, r.secAccel};
        rss_pkg::STATUS_OFS: begin
          n.rdata[FW-1:0] = r.offset;
          n.rdata[rss_pkg::STAT_PEND_BIT] = r.pending;
          n.rdata[rss_pkg::STAT_BUSY_BIT] = r.nvmBusy;
          n.rdata[rss_pkg::STAT_ACT_BIT] = remoteOn;
        end
        rss_pkg::SETFREQ_OFS: n.rdata[FW-1:0] = r.setFreq;
        default: n.rresp = rss_pkg::RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.remoteSel <= rss_pkg::SEL_RST;
      r.opMode <= rss_pkg::MODE_RST;
      r.maxLimit <= rss_pkg::MAXF_RST;
      r.hsLimit <= rss_pkg::HSL_RST;
      r.normAccel <= rss_pkg::RAMP_RST;
      r.normDecel <= rss_pkg::RAMP_RST;
      r.secAccel <= rss_pkg::RAMP_RST;
      r.secDecel <= rss_pkg::RAMP_RST;
    end else begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign setFreq = r.setFreq;
  assign runRequest = r.runReq;
  assign multiSpeedSel = r.multiSpeed;
  assign nvmWriteReq = r.nvmReq;
  assign nvmWriteData = r.nvmData;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  nvm_req_pulse_a: assert property (r.nvmReq |=> !r.nvmReq) // [R21]
    else $error("write request longer than one cycle");
  nvm_no_overlap_a: assert property (r.nvmBusy && !nvmWriteAck |=> !r.nvmReq) // [R21]
    else $error("write request before acknowledge");
  offset_range_a: assert property (r.offset <= $past(curLimit)) // [R7]
    else $error("offset above limit");
  setfreq_cap_a: assert property (remoteOn |=> r.setFreq <= $past(cap)) // [R8]
    else $error("set frequency above cap");
  start_fall_wr_a: assert property (storeOn && startFall && !r.nvmBusy |=> r.nvmReq) // [R3]
    else $error("no write on start release");
  minute_same_a: assert property (minuteTick && r.offset == r.lastCheck && !startFall // [R5]
                                  && !r.pending |=> !r.nvmReq)
    else $error("write without setpoint change");
  disabled_base_a: assert property (jogActive || pidActive |=> // [R13]
                                    r.setFreq == $past(baseCmd))
    else $error("remote offset applied while disabled");
  multi_speed_a: assert property (r.remoteSel == rss_pkg::SEL_MULTI |=> // [R18]
                                  r.multiSpeed == $past({speedUpInput, speedDownInput,
                                                         setpointClearInput}))
    else $error("multi-speed select not passed through");
  mode3_clear_a: assert property (remoteOn && r.remoteSel == rss_pkg::SEL_CLEAR // [R19]
                                  && startFall && !nvmRestoreValid |=> r.offset == '0)
    else $error("offset not cleared on start release");
  no_store_a: assert property (r.remoteSel != rss_pkg::SEL_STORE && !r.pending // [R2]
                               && !r.awHeld |=> !r.nvmReq [*2])
    else $error("write with storage disabled");

  minute_write_c: cover property (minuteTick && storeOn ##1 r.nvmReq);
  start_write_c: cover property (storeOn && startFall ##1 r.nvmReq);
  restore_c: cover property (nvmRestoreValid && r.remoteSel == rss_pkg::SEL_STORE);
  bus_write_c: cover property (r.bvalid && bready);
endmodule

// [core/rss_pkg.sv]
// constants shared by the remote speed setpoint logic
package rss_pkg;
  // timing base
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MINUTE_S = 60;
  localparam int MINUTE_TICKS = MINUTE_S * 1_000_000 / TICK_US;

  // register bus
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] LIMIT_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] NORM_RAMP_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] SEC_RAMP_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] SETFREQ_OFS = 5'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // field positions
  localparam int SEL_LSB = 0;
  localparam int MODE_LSB = 2;
  localparam int T4_BIT = 5;
  localparam int HSL_BIT = 6;
  localparam int HI_LSB = 16;
  localparam int STAT_PEND_BIT = 16;
  localparam int STAT_BUSY_BIT = 17;
  localparam int STAT_ACT_BIT = 18;

  // reset values
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] MAXF_RST = 16'h1388;
  localparam logic [15:0] HSL_RST = 16'h2ee0;
  localparam logic [15:0] RAMP_RST = 16'h0005;

  // remote function select codes
  localparam logic [1:0] SEL_MULTI = 2'h0;
  localparam logic [1:0] SEL_STORE = 2'h1;
  localparam logic [1:0] SEL_REMOTE = 2'h2;
  localparam logic [1:0] SEL_CLEAR = 2'h3;

  // operating mode select codes
  localparam logic [2:0] MODE_PANEL = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_COMB = 3'h3;
  localparam logic [2:0] MODE_EXT4 = 3'h4;
  localparam logic [2:0] MODE_NET = 3'h6;
endpackage

// [tb/nvm_store_model.sv]
// non-volatile store model: delayed acknowledge and power-up replay
`timescale 1ns/1ns
module nvm_store_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nvmWriteReq,
  input wire logic [15:0] nvmWriteData,
  input wire logic [3:0] ackDelay,
  input wire logic restoreGo,
  output logic nvmWriteAck,
  output logic nvmRestoreValid,
  output logic [15:0] nvmRestoreData,
  output logic [15:0] storedVal,
  output int writeCount,
  output logic overlapSeen
);
  logic [3:0] waitCnt;
  logic busy;
  // stored word survives reset like the real memory
  always_ff @(posedge clk) begin
    if (nvmWriteReq) begin
      storedVal <= nvmWriteData;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      waitCnt <= 4'h0;
      nvmWriteAck <= 1'b0;
      writeCount <= 0;
      overlapSeen <= 1'b0;
      nvmRestoreValid <= 1'b0;
      nvmRestoreData <= 16'h5a5a;
    end else begin
      nvmWriteAck <= busy && waitCnt == 4'h0;
      nvmRestoreValid <= restoreGo;
      // data lines wander outside the replay pulse
      nvmRestoreData <= restoreGo ? storedVal : ~nvmRestoreData;
      if (nvmWriteReq) begin
        busy <= 1'b1;
        waitCnt <= ackDelay;
        writeCount <= writeCount + 1;
        overlapSeen <= overlapSeen | busy;
      end else if (busy) begin
        busy <= waitCnt != 4'h0;
        waitCnt <= waitCnt - 4'h1;
      end
    end
  end
endmodule

// [tb/test_remote_speed_setpoint.sv]
// self-checking bench for the remote speed setpoint block
`timescale 1ns/1ns
module test_remote_speed_setpoint;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, ackDelay = 4'h0, strbSel = 4'hf;
  logic upIn = 0, downIn = 0, clrIn = 0, fwdIn = 0, revIn = 0, rtIn = 0;
  logic jog = 0, pid = 0, restoreGo = 0;
  logic [15:0] panelCmd = 16'h0, extCmd = 16'h0, t4Cmd = 16'h0, netCmd = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, runRequest, nvmWriteReq, nvmWriteAck;
  logic nvmRestoreValid, overlapSeen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [2:0] multiSpeedSel;
  logic [15:0] setFreq, nvmWriteData, nvmRestoreData, storedVal, off;
  logic [31:0] rstVal [4] = '{32'h0, 32'h2ee01388, 32'h00050005, 32'h00050005};
  logic [2:0] modes [6];
  int writeCount, wc, err_count = 0, samples_checked = 0, cycles = 0;
  always #2 clk = ~clk;
  remote_speed_setpoint #(.FW(16), .PRESCALE(4), .MINUTE_TICKS(5)) u_remote_speed_setpoint (
    .clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .speedUpInput(upIn),
    .speedDownInput(downIn), .setpointClearInput(clrIn), .forwardStartInput(fwdIn),
    .reverseStartInput(revIn), .secondRampSelectInput(rtIn), .jogActive(jog),
    .pidActive(pid), .panelCmd(panelCmd), .externalCmd(extCmd), .terminal4Cmd(t4Cmd),
    .networkCmd(netCmd), .nvmWriteAck(nvmWriteAck), .nvmRestoreValid(nvmRestoreValid),
    .nvmRestoreData(nvmRestoreData), .setFreq(setFreq), .runRequest(runRequest),
    .multiSpeedSel(multiSpeedSel), .nvmWriteReq(nvmWriteReq), .nvmWriteData(nvmWriteData));
  nvm_store_model u_nvm_store_model (
    .clk(clk), .rst_n(rst_n), .nvmWriteReq(nvmWriteReq), .nvmWriteData(nvmWriteData),
    .ackDelay(ackDelay), .restoreGo(restoreGo), .nvmWriteAck(nvmWriteAck),
    .nvmRestoreValid(nvmRestoreValid), .nvmRestoreData(nvmRestoreData),
    .storedVal(storedVal), .writeCount(writeCount), .overlapSeen(overlapSeen));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_freq(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strbSel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    check_word(32'(bresp), 32'(er));
  endtask
  task automatic axi_read(input logic [4:0] a, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    check_word(32'(rresp), 32'(er));
  endtask
  task automatic get_off;
    axi_read(rss_pkg::STATUS_OFS, rss_pkg::RESP_OKAY);
    off = rd[15:0];
  endtask
  task automatic hold(input logic u, input logic d, input logic r, input int n);
    @(posedge clk);
    upIn <= u;
    downIn <= d;
    rtIn <= r;
    repeat (n) @(posedge clk);
    upIn <= 1'b0;
    downIn <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse_start(input logic f);
    @(posedge clk);
    fwdIn <= f;
    revIn <= !f;
    repeat (3) @(posedge clk);
    fwdIn <= 1'b0;
    revIn <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] s, input logic [2:0] m, input logic t,
                                       input logic h);
    return {25'h0, h, t, m, s};
  endfunction
  function automatic logic [15:0] exp_base(input logic [2:0] m, input logic t);
    case (m)
      rss_pkg::MODE_PANEL: return panelCmd;
      rss_pkg::MODE_COMB: return t ? t4Cmd : panelCmd;
      rss_pkg::MODE_NET: return netCmd;
      default: return extCmd;
    endcase
  endfunction
  function automatic logic [15:0] rnd();
    return 16'($urandom & 32'hfff);
  endfunction
  initial begin
    modes = '{rss_pkg::MODE_PANEL, rss_pkg::MODE_EXT, rss_pkg::MODE_COMB, rss_pkg::MODE_COMB,
              rss_pkg::MODE_EXT4, rss_pkg::MODE_NET};
    void'($urandom(51));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_read(5'(4 * i), rss_pkg::RESP_OKAY);
      check_word(rd, rstVal[i]);
    end
    axi_read(5'h18, rss_pkg::RESP_SLVERR);
    axi_write(5'h1c, 32'hffffffff, rss_pkg::RESP_SLVERR);
    strbSel = 4'h3;
    axi_write(rss_pkg::LIMIT_OFS, 32'h12340007, rss_pkg::RESP_OKAY);
    strbSel = 4'hf;
    axi_read(rss_pkg::LIMIT_OFS, rss_pkg::RESP_OKAY);
    check_word(rd, 32'h2ee00007);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {upIn, downIn, clrIn} <= 3'(i);
      extCmd <= rnd();
      repeat (3) @(posedge clk);
      check_freq(16'(multiSpeedSel), 16'(i));
      check_freq(setFreq, extCmd);
    end
    {upIn, downIn, clrIn} <= 3'h0;
    $display("test multispeed done");
    // frequent toggling goes with select 2
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_REMOTE, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    axi_write(rss_pkg::LIMIT_OFS, 32'h2ee00100, rss_pkg::RESP_OKAY);
    axi_write(rss_pkg::NORM_RAMP_OFS, 32'h00070007, rss_pkg::RESP_OKAY);
    axi_write(rss_pkg::SEC_RAMP_OFS, 32'h0, rss_pkg::RESP_OKAY);
    hold(0, 1, 0, 40);
    get_off;
    check_freq(off, 16'h0);
    hold(1, 0, 1, 48);
    get_off;
    check_freq(16'(off >= 16'd10), 16'h1);
    hold(0, 0, 0, 1);
    clrIn <= 1'b1;
    hold(0, 0, 0, 3);
    clrIn <= 1'b0;
    hold(1, 0, 0, 48);
    get_off;
    check_freq(16'(off >= 16'd1 && off <= 16'd2), 16'h1);
    check_freq(16'(runRequest), 16'h0);
    axi_write(rss_pkg::LIMIT_OFS, 32'h2ee00005, rss_pkg::RESP_OKAY);
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_REMOTE, rss_pkg::MODE_EXT, 0, 1), 2'h0);
    hold(1, 0, 1, 60);
    check_freq(setFreq, extCmd + 16'h5);
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_REMOTE, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    clrIn <= 1'b1;
    hold(0, 0, 0, 3);
    clrIn <= 1'b0;
    hold(1, 0, 1, 60);
    get_off;
    check_freq(off, 16'h5);
    $display("test ramp and limits done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      panelCmd <= rnd();
      extCmd <= rnd();
      t4Cmd <= rnd();
      netCmd <= rnd();
      axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_REMOTE, modes[i], i == 3, 0), 2'h0);
      repeat (3) @(posedge clk);
      check_freq(setFreq, exp_base(modes[i], i == 3) + 16'h5);
    end
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_REMOTE, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    for (int k = 0; k < 2; k++) begin
      jog <= k == 0;
      pid <= k == 1;
      hold(1, 0, 1, 20);
      check_freq(setFreq, extCmd);
    end
    jog <= 1'b0;
    pid <= 1'b0;
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_CLEAR, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    pulse_start(1'b1);
    get_off;
    check_freq(off, 16'h0);
    $display("test modes done");
    axi_write(rss_pkg::LIMIT_OFS, 32'h2ee00002, rss_pkg::RESP_OKAY);
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_STORE, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    clrIn <= 1'b1;
    repeat (45) @(posedge clk);
    wc = writeCount;
    pulse_start(1'b1);
    check_freq(16'(writeCount - wc), 16'h1);
    check_freq(storedVal, 16'h0);
    clrIn <= 1'b0;
    wc = writeCount;
    hold(1, 0, 1, 16);
    repeat (30) @(posedge clk);
    check_freq(16'(writeCount - wc), 16'h1);
    check_freq(storedVal, 16'h2);
    repeat (40) @(posedge clk);
    check_freq(16'(writeCount - wc), 16'h1);
    ackDelay <= 4'h8;
    wc = writeCount;
    pulse_start(1'b1);
    check_freq(16'(writeCount - wc), 16'h1);
    pulse_start(1'b0);
    repeat (20) @(posedge clk);
    check_freq(16'(writeCount - wc), 16'h2);
    check_freq(16'(overlapSeen), 16'h0);
    $display("test storage done");
    fwdIn <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    axi_write(rss_pkg::CTRL_OFS, ctrl(rss_pkg::SEL_STORE, rss_pkg::MODE_EXT, 0, 0), 2'h0);
    restoreGo <= 1'b1;
    @(posedge clk);
    restoreGo <= 1'b0;
    repeat (4) @(posedge clk);
    check_freq(setFreq, extCmd + 16'h2);
    check_freq(16'(runRequest), 16'h1);
    axi_read(rss_pkg::SETFREQ_OFS, rss_pkg::RESP_OKAY);
    check_freq(rd[15:0], extCmd + 16'h2);
    $display("test power return done");
    complete_run();
  end
endmodule
